// >>> verilog/adc_frame_consts.svh
// Purpose: timing and frame constants for the serial converter link
// Assumes: host clock 125 MHz, link clock made by the host
// Notes: definitions only
`ifndef ADC_FRAME_CONSTS_SVH
`define ADC_FRAME_CONSTS_SVH

`define ADC_BITS 12
`define LEAD_ZEROS 4
`define ACQ_EDGES 3
`define FRAME_EDGES 16
`define CLK_MHZ 125
`define SCLK_MHZ 16
// least half period that keeps the link clock at or below its rate
`define SCLK_HALF_CYC ((`CLK_MHZ + 2 * `SCLK_MHZ - 1) / (2 * `SCLK_MHZ))
`define CS_IDLE_CYC 2

`endif

// >>> verilog/adc_frame_pkg.sv
// Purpose: state types of both link ends
// Assumes: constants header on the include path
// Notes: one packed struct per module holds all its state
`include "adc_frame_consts.svh"

package adc_frame_pkg;

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_SETUP = 3'b001,
      H_LOW = 3'b010,
      H_HIGH = 3'b011,
      H_TAIL = 3'b100
   } host_state_t;

   typedef struct packed {
      logic [4:0] cnt;
      logic pd;
      logic [`ADC_BITS-1:0] s1;
      logic [`ADC_BITS-1:0] s2;
      logic [`ADC_BITS-1:0] code;
      logic dout;
   } dev_state_t;

   typedef struct packed {
      host_state_t state;
      logic [7:0] div;
      logic [4:0] fcnt;
      logic [4:0] need;
      logic [`ADC_BITS-1:0] sh;
      logic [`ADC_BITS-1:0] result;
      logic cs_n;
      logic sclk;
      logic done;
      logic d1;
      logic d2;
   } host_reg_t;

endpackage

// >>> verilog/adc_link_if.sv
// Purpose: three-wire link between host and converter
// Assumes: host drives chip select and clock, converter drives data
// Notes: released data wire reads low, as through a pull-down
`timescale 1ns/10ps

interface adc_link_if;
   logic cs_n;
   logic sclk;
   logic dout;
   logic dout_oe;
   wire dout_wire;

   // pull-down stands in for the floating pin; oe shows the release itself
   assign dout_wire = dout_oe ? dout : 1'b0;

   modport device (
      input cs_n,
      input sclk,
      output dout,
      output dout_oe
   );

   modport host (
      output cs_n,
      output sclk,
      input dout_wire
   );
endinterface

// >>> verilog/adc_device.sv
// Purpose: converter end of the link: frame counting, sampling, bit output
// Assumes: runs on the link clock; chip select high holds it in power-down
// Notes: the analog result arrives as a two's complement word on sample_code
//
// Notes on behaviour
// - host gives sixteen clocks per sample frame
// - slow rates: 16 MHz clock, sparse frames
// - power down after each conversion until next frame
// - early chip-select rise stops and powers down
// - each bit driven as soon as decided
// - host never drops select on clock rise
// - coincident select fall may shift bits early
// - first result bit on fifth falling edge
// - host stops clock while select is high
// - edges 1-4 zeros, 5-16 result MSB first
// - three cycles sampling, thirteen converting
// - select rise before edge sixteen aborts, floats output
// - result is twelve-bit two's complement
`timescale 1ns/10ps
`include "adc_frame_consts.svh"

module adc_device
   import adc_frame_pkg::*;
(
   input wire logic rstn,
   input wire logic ce,
   input wire logic [`ADC_BITS-1:0] sample_code,
   adc_link_if.device link,
   output logic powered_down,
   output logic [4:0] edge_count,
   output logic [`ADC_BITS-1:0] held_code
);

   dev_state_t st;
   dev_state_t next_st;
   logic frame_rstn;
   logic [4:0] e;

   // select high clears the frame: abort and power-down come from one place
   assign frame_rstn = rstn & ~link.cs_n;

   always_comb begin
      e = st.cnt + 5'h01;
      next_st = st;
      if (ce && !st.pd) begin
         next_st.cnt = e;
         // sample passes two flops while acquiring, settled by the fourth edge
         if (e <= 5'(`ACQ_EDGES)) begin
            next_st.s1 = sample_code;
            next_st.s2 = st.s1;
         end
         if (e == 5'(`ACQ_EDGES + 1)) begin
            next_st.code = st.s2;
         end
         if (e <= 5'(`LEAD_ZEROS)) begin
            next_st.dout = 1'b0;
         end else begin
            // no wait for the full word: partial frames are valid
            next_st.dout = st.code[4'(5'(`FRAME_EDGES) - e)];
         end
         if (e == 5'(`FRAME_EDGES)) begin
            next_st.pd = 1'b1;
         end
      end
   end

   // edges are counted from select fall; a select fall on a clock fall may
   // let that same fall count, moving every bit one edge early
   always_ff @(negedge link.sclk or negedge frame_rstn) begin
      if (!frame_rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign link.dout = st.dout;
   assign link.dout_oe = ~link.cs_n;
   assign powered_down = link.cs_n | st.pd;
   assign edge_count = st.cnt;
   assign held_code = st.code;

endmodule

// >>> verilog/adc_host.sv
// Purpose: host end: frames conversions, makes the link clock, gathers bits
// Assumes: clk at 125 MHz; link clock is a divided copy driven out
// Notes: nbits from one to eleven short-cycles the frame
`timescale 1ns/10ps
`include "adc_frame_consts.svh"

module adc_host
   import adc_frame_pkg::*;
#(
   parameter logic [7:0] HALF_CYC = 8'(`SCLK_HALF_CYC)
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic start,
   input wire logic [3:0] nbits,
   output logic ready,
   output logic done,
   output logic [`ADC_BITS-1:0] result,
   adc_link_if.host link
);

   host_reg_t r;
   host_reg_t next_r;

   always_comb begin
      next_r = r;
      if (ce) begin
         next_r.d1 = link.dout_wire;
         next_r.d2 = r.d1;
         next_r.done = 1'b0;
         unique case (r.state)
            H_IDLE: begin
               // clock parked high and still between frames
               next_r.sclk = 1'b1;
               next_r.cs_n = 1'b1;
               if (start) begin
                  // select falls mid high phase, clear of any clock rise
                  next_r.cs_n = 1'b0;
                  next_r.div = 8'h00;
                  next_r.fcnt = 5'h00;
                  next_r.sh = '0;
                  if (nbits == 4'h0 || nbits > 4'(`ADC_BITS)) begin
                     next_r.need = 5'(`FRAME_EDGES);
                  end else begin
                     next_r.need = 5'(`LEAD_ZEROS) + 5'(nbits);
                  end
                  next_r.state = H_SETUP;
               end
            end
            H_SETUP, H_HIGH: begin
               next_r.div = r.div + 8'h01;
               if (r.div == HALF_CYC - 8'h01) begin
                  next_r.div = 8'h00;
                  if (r.state == H_HIGH && r.fcnt == r.need) begin
                     next_r.cs_n = 1'b1;
                     next_r.result = r.sh;
                     next_r.done = 1'b1;
                     next_r.state = H_TAIL;
                  end else begin
                     next_r.sclk = 1'b0;
                     next_r.fcnt = r.fcnt + 5'h01;
                     next_r.state = H_LOW;
                  end
               end
            end
            H_LOW: begin
               next_r.div = r.div + 8'h01;
               if (r.div == HALF_CYC - 8'h01) begin
                  next_r.div = 8'h00;
                  next_r.sclk = 1'b1;
                  // bit shifted on this low phase's fall, taken at the rise
                  if (r.fcnt > 5'(`LEAD_ZEROS)) begin
                     next_r.sh[4'(5'(`FRAME_EDGES) - r.fcnt)] = r.d2;
                  end
                  next_r.state = H_HIGH;
               end
            end
            H_TAIL: begin
               next_r.div = r.div + 8'h01;
               if (r.div == 8'(`CS_IDLE_CYC) - 8'h01) begin
                  next_r.div = 8'h00;
                  next_r.state = H_IDLE;
               end
            end
            default: begin
               next_r.state = H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '{state: H_IDLE, div: 8'h00, fcnt: 5'h00, need: 5'h00, sh: '0,
                result: '0, cs_n: 1'b1, sclk: 1'b1, done: 1'b0, d1: 1'b0, d2: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign link.cs_n = r.cs_n;
   assign link.sclk = r.sclk;
   assign ready = (r.state == H_IDLE);
   assign done = r.done;
   assign result = r.result;

endmodule

// >>> tb/link_chk.sv
// Purpose: watch the three-wire link between host and converter
// Assumes: sample_code stays stable while select is low
// Notes: local edge count, cleared by select like the device
`timescale 1ns/10ps
`include "adc_frame_consts.svh"
module link_chk (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic [`ADC_BITS-1:0] sample_code
);
   logic [4:0] edges;
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         edges <= 5'h00;
      end else begin
         edges <= edges + 5'h01;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   AST_FLOAT: assert property (dout_oe == !cs_n) else $error("enable off");
   AST_LEAD: assert property (!cs_n && edges < 5 |-> !dout) else $error("lead");
   AST_FIRST: assert property (!cs_n && edges == 5 |-> dout == sample_code[11])
      else $error("first");
   AST_MSB: assert property (!cs_n && edges >= 5 && edges <= 16
      |-> dout == sample_code[5'd16 - edges]) else $error("bit");
   AST_HOLD: assert property (!cs_n && $rose(sclk) |-> $stable(dout)) else $error("hold");
   AST_ACQ: assert property ($fell(cs_n) |-> !dout [*8]) else $error("acq");
   AST_SEL: assert property ($fell(cs_n) |-> sclk) else $error("sel");
   AST_CNT: assert property (!cs_n |-> edges <= 16) else $error("count");
   AST_END: assert property (!cs_n && edges == 16 |-> ##[1:12] cs_n) else $error("end");
endmodule

// >>> tb/test_adc_serial_frame_power_control.sv
// Purpose: bench for host and converter ends
// Assumes: host derives the link clock from clk
// Notes: sample_code stands in for the analog side
`timescale 1ns/10ps
`include "adc_frame_consts.svh"
module test_adc_serial_frame_power_control;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   logic host_ce = 1'b1;
   logic [3:0] nbits = 4'h0;
   logic [11:0] sample_code = 12'h000;
   logic ready, done, powered_down;
   logic [4:0] edge_count;
   logic [11:0] result, held_code;
   int miscompares = 0;
   int n_tests = 0;
   adc_link_if link ();
   adc_host adc_host_i (.clk(clk), .rstn(rstn), .ce(host_ce), .start(start), .nbits(nbits),
      .ready(ready), .done(done), .result(result), .link(link.host));
   adc_device adc_device_i (.rstn(rstn), .ce(1'b1), .sample_code(sample_code),
      .link(link.device), .powered_down(powered_down), .edge_count(edge_count),
      .held_code(held_code));
   link_chk link_chk_i (.clk(clk), .rstn(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
      .dout(link.dout), .dout_oe(link.dout_oe), .sample_code(sample_code));
   always #4 clk = ~clk;
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("tests %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // deepest edge and power flag at edge 16 are caught while select is low
   task automatic frame(input logic [11:0] c, input logic [3:0] nb, output logic [11:0] r,
      output logic [4:0] mx, output logic pd, output logic [11:0] hc);
      int i;
      mx = 5'h00;
      pd = 1'b0;
      hc = 12'h000;
      for (i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk);
      sample_code = c;
      nbits = nb;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (i = 0; i < 300 && done !== 1'b1; i++) begin
         @(negedge clk);
         if (link.cs_n === 1'b0 && edge_count > mx) mx = edge_count;
         // held code clears when select rises, so it is caught at edge 16
         if (link.cs_n === 1'b0 && edge_count == 5'h10) begin
            pd = powered_down;
            hc = held_code;
         end
      end
      cmp({11'h000, done}, 12'h001);
      r = result;
   endtask
   task automatic t_full();
      logic [11:0] r;
      logic [4:0] mx;
      logic pd;
      logic [11:0] hc;
      logic [11:0] codes [4] = '{12'h7ff, 12'h000, 12'hfff, 12'h800};
      foreach (codes[k]) begin
         frame(codes[k], 4'hc, r, mx, pd, hc);
         cmp(r, codes[k]);
         cmp(hc, codes[k]);
         cmp({6'h00, pd, mx}, 12'h030);
      end
      $display("full frames done");
   endtask
   task automatic t_short();
      logic [11:0] r;
      logic [4:0] mx;
      logic pd;
      logic [11:0] hc;
      frame(12'ha5c, 4'h8, r, mx, pd, hc);
      cmp(r, 12'ha50);
      cmp({7'h00, mx}, 12'h00c);
      frame(12'h9ff, 4'h1, r, mx, pd, hc);
      cmp(r, 12'h800);
      cmp({7'h00, mx}, 12'h005);
      cmp({8'h00, link.cs_n, link.sclk, link.dout_oe, link.dout_wire}, 12'h00c);
      $display("short frames done");
   endtask
   // host ce low must hold the link clock, so the device edge count stands
   task automatic t_freeze();
      logic [11:0] r;
      logic [4:0] mx;
      logic pd;
      logic [11:0] hc;
      fork
         frame(12'h3c6, 4'hc, r, mx, pd, hc);
         begin
            wait (link.cs_n === 1'b0);
            repeat (20) @(negedge clk);
            host_ce = 1'b0;
            repeat (20) @(negedge clk);
            cmp({7'h00, edge_count}, 12'h002);
            host_ce = 1'b1;
         end
      join
      cmp(r, 12'h3c6);
      $display("freeze frame done");
   endtask
   initial begin
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      t_full();
      t_short();
      t_freeze();
      wrap_up();
   end
   initial begin
      #200000;
      miscompares++;
      wrap_up();
   end
endmodule
